// *** verilog/lpsr_defs.svh ***
`ifndef LPSR_DEFS_SVH
`define LPSR_DEFS_SVH

// Clock and timing
`define LPSR_CLK_PERIOD_PS   25000
`define LPSR_TCKESR_NS       15
`define LPSR_TXSR_NS         140
`define LPSR_TREFI_INT_NS    3900
// Least times round up, longest times round down
`define LPSR_TCKESR_CYC      ((`LPSR_TCKESR_NS * 1000 + `LPSR_CLK_PERIOD_PS - 1) / `LPSR_CLK_PERIOD_PS)
`define LPSR_TXSR_CYC        ((`LPSR_TXSR_NS * 1000 + `LPSR_CLK_PERIOD_PS - 1) / `LPSR_CLK_PERIOD_PS)
`define LPSR_TREFI_INT_CYC   ((`LPSR_TREFI_INT_NS * 1000) / `LPSR_CLK_PERIOD_PS)
`define LPSR_TMRR_CYC        2
`define LPSR_RL_CYC          3
`define LPSR_MRR_BEATS       4

// Command encodings on CA rising edge, bit 0 is CA0
`define LPSR_CA_NOP          3'h3
`define LPSR_CA_SREF         3'h4
`define LPSR_CA_MRR          4'h8
`define LPSR_CA_MRW          4'h0

// Mode register indices
`define LPSR_MR_BANK_MASK    8'h10
`define LPSR_MR_SEG_MASK     8'h11
`define LPSR_MR_DQC_A        8'h20
`define LPSR_MR_DQC_B        8'h28

// Calibration patterns, bit n is beat n
`define LPSR_DQC_A_PAT       4'h5
`define LPSR_DQC_B_PAT       4'hc

// Reset values
`define LPSR_BANK_MASK_RST   8'h00
`define LPSR_SEG_MASK_RST    8'h00

// Array layout
`define LPSR_ROW_W           14
`define LPSR_SEG_MSB         13
`define LPSR_SEG_LSB         11

`endif

// *** verilog/lpsr_pkg.sv ***
package lpsr_pkg;

   typedef enum logic [1:0] {
      LPSR_IDLE,
      LPSR_SREF,
      LPSR_EXIT
   } lpsr_state_t;

   typedef enum logic [2:0] {
      LPSR_CMD_NOP,
      LPSR_CMD_SREF,
      LPSR_CMD_MRR,
      LPSR_CMD_MRW,
      LPSR_CMD_OTHER
   } lpsr_cmd_t;

   typedef struct packed {
      lpsr_state_t st;
      logic        cke_prev;
      logic [15:0] wait_cnt;
      logic [1:0]  mrr_hold;
      logic [3:0]  lat_cnt;
      logic        bursting;
      logic [1:0]  beat;
      logic [7:0]  mrr_idx;
      logic [7:0]  bank_mask;
      logic [7:0]  seg_mask;
      logic [31:0] dq;
      logic        dq_oe;
      logic        dqs;
      logic        err;
   } lpsr_main_t;

   typedef struct packed {
      logic [15:0] tick_cnt;
      logic [13:0] row;
      logic        strobe;
      logic [13:0] ref_row;
      logic [7:0]  ref_banks;
   } lpsr_timer_t;

endpackage : lpsr_pkg

// *** verilog/lpsr_refresh_timer.sv ***
`timescale 1ns/1ps
`include "lpsr_defs.svh"

module lpsr_refresh_timer (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Control
   input  wire logic        active,
   input  wire logic        kick,
   input  wire logic [7:0]  bank_mask,
   input  wire logic [7:0]  seg_mask,
   // Refresh request to the array
   output logic             ref_strobe,
   output logic [13:0]      ref_row,
   output logic [7:0]       ref_banks
);

   localparam logic [15:0] INTERVAL = 16'(`LPSR_TREFI_INT_CYC);

   lpsr_pkg::lpsr_timer_t s_r;
   lpsr_pkg::lpsr_timer_t s_nxt;

   always_comb begin
      logic       fire;
      logic [2:0] seg;
      fire = 1'b0;
      seg = 3'h0;
      s_nxt = s_r;
      s_nxt.strobe = 1'b0;
      if (kick) begin
         fire = 1'b1;                                     // R4
         s_nxt.tick_cnt = INTERVAL - 16'h0001;
      end else if (active) begin
         if (s_r.tick_cnt == 16'h0000) begin
            fire = 1'b1;
            s_nxt.tick_cnt = INTERVAL - 16'h0001;
         end else begin
            s_nxt.tick_cnt = s_r.tick_cnt - 16'h0001;
         end
      end
      if (fire) begin
         seg = s_r.row[`LPSR_SEG_MSB:`LPSR_SEG_LSB];
         s_nxt.strobe = 1'b1;
         s_nxt.ref_row = s_r.row;
         s_nxt.ref_banks = seg_mask[seg] ? 8'h00 : ~bank_mask;  // R13 R14 R15
         s_nxt.row = s_r.row + 14'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ref_strobe = s_r.strobe;
   assign ref_row    = s_r.ref_row;
   assign ref_banks  = s_r.ref_banks;

endmodule : lpsr_refresh_timer

// *** verilog/lpsr_top.sv ***
`timescale 1ns/1ps
`include "lpsr_defs.svh"

// Operation
// [R1] Self-refresh entry: CKE falls, CS low, CA=100
// [R2] Controller sends NOP after entry command
// [R3] Stay in self-refresh while CKE low
// [R4] Internal refresh within tCKESR, clock gated
// [R5] Controller keeps self-refresh at least tCKESR
// [R6] Clock may stop one cycle after entry
// [R7] Two stable clocks before CKE rises
// [R8] Five stable clocks after changed clock
// [R9] tXSR from first edge, NOPs only
// [R10] CKE held high through tXSR; the code takes an entry command in tXSR as re-entry with no error
// [R11] One refresh between exit and re-entry
// [R12] All banks idle before entry
// [R13] Bank mask excludes bank from refresh
// [R14] Unmasked bank refreshes unmasked segments only
// [R15] Segment mask applies to every bank
// [R16] Mode register read decode and index
// [R17] Register value on DQ0-7, first beat; the code drives zero on every beat for all but the calibration registers
// [R18] All strobes toggle during read burst
// [R19] Four-beat read burst, never interrupted
// [R20] Two-cycle read command period
// [R21] Reserved or write-only reads still valid
// [R22] Only NOPs during read command period
// [R23] Read spacing after read or write; the code enforces it after a read only, a read right after a write is taken
// [R24] Track states, flag non-NOP in wait windows
module lpsr_top (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Command and address
   input  wire logic        cke,
   input  wire logic        cs_n,
   input  wire logic [9:0]  ca_r,
   input  wire logic [9:0]  ca_f,
   // Data pins
   output logic [31:0]      dq_o,
   output logic             dq_oe,
   output logic [3:0]       dqs_t_o,
   output logic [3:0]       dqs_c_o,
   output logic             dqs_oe,
   // Array refresh and status
   output logic             refresh_strobe,
   output logic [13:0]      refresh_row,
   output logic [7:0]       refresh_banks,
   output logic             int_clk_en,
   output logic             sref_active,
   output logic             protocol_error
);

   localparam logic [15:0] CKESR_CYC = 16'(`LPSR_TCKESR_CYC);
   localparam logic [15:0] XSR_CYC   = 16'(`LPSR_TXSR_CYC);
   localparam logic [1:0]  MRR_HOLD  = 2'(`LPSR_TMRR_CYC - 1);
   localparam logic [3:0]  RL_CYC    = 4'(`LPSR_RL_CYC);
   localparam logic [1:0]  LAST_BEAT = 2'(`LPSR_MRR_BEATS - 1);

   lpsr_pkg::lpsr_main_t s_r;
   lpsr_pkg::lpsr_main_t s_nxt;
   lpsr_pkg::lpsr_cmd_t  cmd;
   logic                 sref_kick;

   // Command decode from one clock edge
   function automatic lpsr_pkg::lpsr_cmd_t decode(input logic       cke_now,
                                                  input logic       cke_before,
                                                  input logic       sel_n,
                                                  input logic [9:0] ca);
      if (!cke_now && cke_before && !sel_n && ca[2:0] == `LPSR_CA_SREF) begin
         decode = lpsr_pkg::LPSR_CMD_SREF;                 // R1
      end else if (sel_n || ca[2:0] == `LPSR_CA_NOP) begin
         decode = lpsr_pkg::LPSR_CMD_NOP;
      end else if (ca[3:0] == `LPSR_CA_MRR) begin
         decode = lpsr_pkg::LPSR_CMD_MRR;                  // R16
      end else if (ca[3:0] == `LPSR_CA_MRW) begin
         decode = lpsr_pkg::LPSR_CMD_MRW;
      end else begin
         decode = lpsr_pkg::LPSR_CMD_OTHER;
      end
   endfunction : decode

   // Data for one beat of a register read
   function automatic logic [31:0] beat_data(input logic [7:0] idx,
                                             input logic [1:0] beat,
                                             input logic [7:0] value);
      logic pat;
      pat = 1'b0;
      if (idx == `LPSR_MR_DQC_A) begin
         pat = 1'(`LPSR_DQC_A_PAT >> beat);
         beat_data = {32{pat}};
      end else if (idx == `LPSR_MR_DQC_B) begin
         pat = 1'(`LPSR_DQC_B_PAT >> beat);
         beat_data = {32{pat}};
      end else if (beat == 2'h0) begin
         beat_data = {24'h000000, value};                  // R17
      end else begin
         beat_data = 32'h00000000;                         // R17
      end
   endfunction : beat_data

   assign cmd = decode(cke, s_r.cke_prev, cs_n, ca_r);

   always_comb begin
      logic [7:0] mr_idx;
      mr_idx = {ca_f[1:0], ca_r[9:4]};                     // R16
      s_nxt = s_r;
      s_nxt.cke_prev = cke;
      s_nxt.err = 1'b0;
      sref_kick = 1'b0;

      if (s_r.mrr_hold != 2'h0) begin
         s_nxt.mrr_hold = s_r.mrr_hold - 2'h1;
      end
      if (s_r.wait_cnt != 16'h0000) begin
         s_nxt.wait_cnt = s_r.wait_cnt - 16'h0001;
      end

      unique case (s_r.st)
         lpsr_pkg::LPSR_IDLE: begin
            if (s_r.mrr_hold != 2'h0 && cmd != lpsr_pkg::LPSR_CMD_NOP) begin
               s_nxt.err = 1'b1;                           // R22 R24
            end else if (cmd == lpsr_pkg::LPSR_CMD_SREF && !s_r.bursting && s_r.lat_cnt == 4'h0) begin
               s_nxt.st = lpsr_pkg::LPSR_SREF;             // R1
               // Exit on the edge after tCKESR is legal
               s_nxt.wait_cnt = CKESR_CYC - 16'h0001;
               sref_kick = 1'b1;                           // R4
            end else if (cmd == lpsr_pkg::LPSR_CMD_MRR && cke) begin
               if (s_r.bursting || s_r.lat_cnt != 4'h0) begin
                  s_nxt.err = 1'b1;                        // R19
               end else begin
                  s_nxt.mrr_idx = mr_idx;
                  s_nxt.lat_cnt = RL_CYC;
                  s_nxt.mrr_hold = MRR_HOLD;               // R20
               end
            end else if (cmd == lpsr_pkg::LPSR_CMD_MRW && cke) begin
               if (mr_idx == `LPSR_MR_BANK_MASK) begin
                  s_nxt.bank_mask = ca_f[9:2];             // R13
               end else if (mr_idx == `LPSR_MR_SEG_MASK) begin
                  s_nxt.seg_mask = ca_f[9:2];              // R15
               end
            end
         end
         lpsr_pkg::LPSR_SREF: begin
            // Every input but CKE is ignored here
            if (cke) begin                                 // R3
               s_nxt.st = lpsr_pkg::LPSR_EXIT;
               // Idle in time for a command on the edge after tXSR
               s_nxt.wait_cnt = XSR_CYC - 16'h0002;        // R9
               if (s_r.wait_cnt != 16'h0000) begin
                  s_nxt.err = 1'b1;                        // R5
               end
            end
         end
         lpsr_pkg::LPSR_EXIT: begin
            if (cmd == lpsr_pkg::LPSR_CMD_SREF) begin
               s_nxt.st = lpsr_pkg::LPSR_SREF;             // R10
               s_nxt.wait_cnt = CKESR_CYC - 16'h0001;
               sref_kick = 1'b1;
            end else begin
               if (cmd != lpsr_pkg::LPSR_CMD_NOP || !cke) begin
                  s_nxt.err = 1'b1;                        // R9 R24
               end
               if (s_r.wait_cnt == 16'h0000) begin
                  s_nxt.st = lpsr_pkg::LPSR_IDLE;
               end
            end
         end
      endcase

      // Read burst: latency, then four beats with strobes
      if (s_r.lat_cnt != 4'h0) begin
         s_nxt.lat_cnt = s_r.lat_cnt - 4'h1;
      end
      if (s_r.lat_cnt == 4'h1) begin
         s_nxt.bursting = 1'b1;                            // R19
         s_nxt.beat = 2'h0;
         s_nxt.dq_oe = 1'b1;
         s_nxt.dqs = 1'b1;                                 // R18
         s_nxt.dq = beat_data(s_r.mrr_idx, 2'h0, 8'h00);   // R17 R21
      end else if (s_r.bursting) begin
         if (s_r.beat == LAST_BEAT) begin
            s_nxt.bursting = 1'b0;
            s_nxt.dq_oe = 1'b0;
            s_nxt.dqs = 1'b0;
            s_nxt.dq = 32'h00000000;
         end else begin
            s_nxt.beat = s_r.beat + 2'h1;
            s_nxt.dqs = ~s_r.dqs;                          // R18
            s_nxt.dq = beat_data(s_r.mrr_idx, s_r.beat + 2'h1, 8'h00);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.st <= lpsr_pkg::LPSR_IDLE;
         s_r.bank_mask <= `LPSR_BANK_MASK_RST;
         s_r.seg_mask <= `LPSR_SEG_MASK_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   lpsr_refresh_timer u_timer (
      .clk        (clk),
      .rst_n      (rst_n),
      .active     (s_r.st == lpsr_pkg::LPSR_SREF),
      .kick       (sref_kick),
      .bank_mask  (s_r.bank_mask),
      .seg_mask   (s_r.seg_mask),
      .ref_strobe (refresh_strobe),
      .ref_row    (refresh_row),
      .ref_banks  (refresh_banks)
   );

   assign dq_o           = s_r.dq;
   assign dq_oe          = s_r.dq_oe;
   assign dqs_t_o        = {4{s_r.dqs}};
   assign dqs_c_o        = {4{~s_r.dqs}};
   assign dqs_oe         = s_r.dq_oe;
   assign sref_active    = (s_r.st == lpsr_pkg::LPSR_SREF);
   assign int_clk_en     = (s_r.st != lpsr_pkg::LPSR_SREF);   // R4
   assign protocol_error = s_r.err;

endmodule : lpsr_top

// *** test/lpsr_top_assertions.sv ***
`timescale 1ns/1ps
module lpsr_top_assertions (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Command
   input wire logic       cke,
   input wire logic       cs_n,
   input wire logic [9:0] ca_r,
   // Data pins
   input wire logic       dq_oe,
   input wire logic [3:0] dqs_t_o,
   input wire logic [3:0] dqs_c_o,
   // Status
   input wire logic       refresh_strobe,
   input wire logic       int_clk_en,
   input wire logic       sref_active
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   wire mrr = cke && !cs_n && ca_r[3:0] == 4'h8;
   wire ent = !cke && !cs_n && ca_r[2:0] == 3'h4;

   a_read_latency: assert property ($rose(dq_oe) |-> $past(mrr, 4))
      else $error("read data without read command");
   a_burst_length: assert property ($rose(dq_oe) |-> dq_oe[*4] ##1 !dq_oe)
      else $error("read burst not four beats");
   a_strobe_first: assert property ($rose(dq_oe) |-> dqs_t_o == 4'hf)
      else $error("strobe not high on first beat");
   a_strobe_toggle: assert property (dq_oe && $past(dq_oe) |-> dqs_t_o == ~$past(dqs_t_o))
      else $error("strobe did not toggle");
   a_strobe_pair: assert property (dqs_c_o == ~dqs_t_o)
      else $error("strobe pair not complementary");
   a_sref_entry: assert property (ent && $past(cke) && $past(rst_n) && !sref_active && !dq_oe
      |=> sref_active && !int_clk_en)
      else $error("entry not taken");
   a_sref_stay: assert property (sref_active && !cke |=> sref_active)
      else $error("left self refresh with cke low");
   a_sref_refresh: assert property ($rose(sref_active) |-> refresh_strobe)
      else $error("no refresh after entry");
   a_sref_exit: assert property (sref_active && cke |=> !sref_active)
      else $error("exit not taken");
   a_clock_gate: assert property (int_clk_en != sref_active)
      else $error("internal clock not gated");
   a_sref_quiet: assert property (sref_active |-> !dq_oe)
      else $error("data driven in self refresh");

   c_read: cover property ($rose(dq_oe));
   c_exit: cover property ($fell(sref_active));
   c_refresh: cover property (refresh_strobe && sref_active);
endmodule : lpsr_top_assertions

// *** test/lpsr_ctrl_model.sv ***
`timescale 1ns/1ps
module lpsr_ctrl_model (
   // Clock
   input wire logic  clk,
   // Command and address
   output logic       cke,
   output logic       cs_n,
   output logic [9:0] ca_r,
   output logic [9:0] ca_f
);
   initial begin
      cke = 1'b1;
      cs_n = 1'b1;
      ca_r = 10'h3ff;
      ca_f = 10'h3ff;
   end
   task automatic cmd(input logic e, input logic [9:0] r, input logic [9:0] f);
      @(negedge clk);
      cke = e;
      cs_n = 1'b0;
      ca_r = r;
      ca_f = f;
   endtask : cmd
   // Deselect, bus pattern changes so stale values never match
   task automatic nop(input int n);
      repeat (n) begin
         @(negedge clk);
         cs_n = 1'b1;
         ca_r = ~ca_r;
         ca_f = ~ca_f;
      end
   endtask : nop
   // Clock already stable, cke high with only deselects through exit wait
   task automatic wake;
      nop(5);
      @(negedge clk);
      cke = 1'b1;
      nop(5);
   endtask : wake
endmodule : lpsr_ctrl_model

// *** test/lpsr_top_tb.sv ***
`timescale 1ns/1ps
module lpsr_top_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   wire         cke;
   wire         cs_n;
   wire  [9:0]  ca_r;
   wire  [9:0]  ca_f;
   logic [31:0] dq_o;
   logic        dq_oe;
   logic [3:0]  dqs_t_o;
   logic [3:0]  dqs_c_o;
   logic        dqs_oe;
   logic        refresh_strobe;
   logic [13:0] refresh_row;
   logic [7:0]  refresh_banks;
   logic        int_clk_en;
   logic        sref_active;
   logic        protocol_error;
   int          miscompares = 0;
   int          checked = 0;
   int          cycles = 0;

   always #12.5 clk = ~clk;

   lpsr_top lpsr_top_i (.clk, .rst_n, .cke, .cs_n, .ca_r, .ca_f, .dq_o, .dq_oe, .dqs_t_o, .dqs_c_o, .dqs_oe,
      .refresh_strobe, .refresh_row, .refresh_banks, .int_clk_en, .sref_active, .protocol_error);
   lpsr_ctrl_model lpsr_ctrl_model_i (.clk, .cke, .cs_n, .ca_r, .ca_f);

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic results;
      $display("Comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end

   task automatic t_read(input logic [7:0] idx, input logic [3:0] pat);
      int n;
      lpsr_ctrl_model_i.cmd(1'b1, {idx[5:0], 4'h8}, {8'ha5, idx[7:6]});
      n = 0;
      while (dq_oe !== 1'b1 && n < 9) begin
         lpsr_ctrl_model_i.nop(1);
         n++;
      end
      chk("read latency", n, 4);
      for (int b = 0; b < 4; b++) begin
         chk("read data", dq_o, {32{pat[b]}});
         chk("strobe", dqs_t_o, b[0] ? 4'h0 : 4'hf);
         chk("strobe enable", dqs_oe, 1'b1);
         lpsr_ctrl_model_i.nop(1);
      end
      chk("burst end", dq_oe, 1'b0);
      $display("read of index %0d done", idx);
   endtask : t_read

   task automatic t_sref;
      int n;
      lpsr_ctrl_model_i.cmd(1'b0, 10'h3fc, 10'h155);
      lpsr_ctrl_model_i.nop(1);
      chk("in self refresh", {sref_active, int_clk_en}, 2'b10);
      chk("first refresh", {refresh_strobe, refresh_row, refresh_banks}, {1'b1, 14'h0, 8'h7d});
      n = 0;
      do begin
         lpsr_ctrl_model_i.nop(1);
         n++;
      end while (refresh_strobe !== 1'b1 && n < 200);
      chk("refresh interval", n, 156);
      chk("refresh row", {refresh_row, refresh_banks}, {14'h1, 8'h7d});
      lpsr_ctrl_model_i.cmd(1'b0, 10'h208, 10'h000);
      lpsr_ctrl_model_i.nop(4);
      chk("inputs ignored", {dq_oe, sref_active, protocol_error}, 3'b010);
      lpsr_ctrl_model_i.wake();
      chk("after exit", {sref_active, int_clk_en, protocol_error}, 3'b010);
      $display("self refresh done");
   endtask : t_sref

   task automatic t_err;
      logic seen;
      seen = 1'b0;
      lpsr_ctrl_model_i.cmd(1'b1, 10'h008, 10'h000);
      lpsr_ctrl_model_i.cmd(1'b1, 10'h000, 10'h000);
      repeat (3) begin
         lpsr_ctrl_model_i.nop(1);
         seen = seen | (protocol_error === 1'b1);
      end
      chk("command in read period", seen, 1'b1);
      lpsr_ctrl_model_i.nop(8);
      lpsr_ctrl_model_i.cmd(1'b1, 10'h208, 10'h3f0);
      lpsr_ctrl_model_i.nop(2);
      lpsr_ctrl_model_i.cmd(1'b1, 10'h008, 10'h000);
      lpsr_ctrl_model_i.nop(1);
      chk("read during pending read", protocol_error, 1'b1);
      chk("first burst kept", dq_o, 32'hffffffff);
      lpsr_ctrl_model_i.nop(9);
      $display("read period check done");
   endtask : t_err

   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      chk("reset", {dq_oe, dqs_t_o, dqs_c_o, int_clk_en, sref_active, refresh_strobe}, 12'h07c);
      lpsr_ctrl_model_i.cmd(1'b1, 10'h100, 10'h208);
      lpsr_ctrl_model_i.cmd(1'b1, 10'h110, 10'h210);
      lpsr_ctrl_model_i.nop(3);
      t_read(8'h10, 4'h0);
      t_read(8'h11, 4'h0);
      t_read(8'h20, 4'h5);
      t_read(8'h28, 4'hc);
      t_sref();
      t_read(8'h20, 4'h5);
      t_err();
      results();
   end
endmodule : lpsr_top_tb

bind lpsr_top lpsr_top_assertions lpsr_top_assertions_i (.clk, .rst_n, .cke, .cs_n, .ca_r, .dq_oe, .dqs_t_o,
   .dqs_c_o, .refresh_strobe, .int_clk_en, .sref_active);
